// file: rtl/tcc_pkg.sv
// Purpose: constants for one timer channel (output actions, value and status registers)
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: offsets are byte addresses of aligned words
package tcc_pkg;
  localparam logic [7:0] TCC_CTRL_OFS = 8'h00;
  localparam logic [7:0] TCC_MODE_OFS = 8'h04;
  localparam logic [7:0] TCC_COUNT_OFS = 8'h10;
  localparam logic [7:0] TCC_HOLD_A_OFS = 8'h14;
  localparam logic [7:0] TCC_HOLD_B_OFS = 8'h18;
  localparam logic [7:0] TCC_LIMIT_OFS = 8'h1c;
  localparam logic [7:0] TCC_STATUS_OFS = 8'h20;

  // control word bits (write only)
  localparam int TCC_CTRL_CLK_EN = 0;
  localparam int TCC_CTRL_CLK_DIS = 1;
  localparam int TCC_CTRL_SOFT_TRIG = 2;

  // mode word fields
  localparam int TCC_MODE_SHAPING = 15;
  localparam int TCC_MODE_A_ON_HOLD_A = 16;
  localparam int TCC_MODE_A_ON_LIMIT = 18;
  localparam int TCC_MODE_A_ON_EXT = 20;
  localparam int TCC_MODE_A_ON_SOFT = 22;
  localparam int TCC_MODE_B_ON_HOLD_B = 24;
  localparam int TCC_MODE_B_ON_LIMIT = 26;
  localparam int TCC_MODE_B_ON_EXT = 28;
  localparam int TCC_MODE_B_ON_SOFT = 30;

  // status bits
  localparam int TCC_ST_WRAP = 0;
  localparam int TCC_ST_DOUBLE_LOAD = 1;
  localparam int TCC_ST_MATCH_A = 2;
  localparam int TCC_ST_MATCH_B = 3;
  localparam int TCC_ST_MATCH_LIMIT = 4;
  localparam int TCC_ST_LOAD_A = 5;
  localparam int TCC_ST_LOAD_B = 6;
  localparam int TCC_ST_EXT_TRIG = 7;
  localparam int TCC_ST_CLOCK_ON = 16;
  localparam int TCC_ST_LINE_A_ECHO = 17;
  localparam int TCC_ST_LINE_B_ECHO = 18;

  localparam logic [15:0] TCC_VALUE_RESET = 16'h0000;
  localparam logic [15:0] TCC_COUNT_TOP = 16'hffff;
  localparam logic [31:0] TCC_MODE_RESET = 32'h0000_0000;
  localparam int TCC_PRESCALE_DEFAULT = 2;

  typedef enum logic [1:0] {
    TCC_ACT_NONE,
    TCC_ACT_SET,
    TCC_ACT_CLEAR,
    TCC_ACT_TOGGLE
  } tcc_action_t;
endpackage

// file: rtl/tcc_top.sv
// Purpose: one 16-bit timer channel: counter, hold/limit values, line actions, read-clearing status
// Assumes: single 10 MHz clock, synchronous active-high reset, classic wishbone slave
// Notes: counter advances on a divided enable pulse; line inputs pass two flip-flops
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ns

// How it works
// R1 - limit match in waveform mode applies line a limit action: none, high, low, invert
// R2 - selected external event applies line a external-event action to line a
// R3 - software trigger applies line a soft-trigger action to line a
// R4 - waveform match on hold b applies line b second-match action
// R5 - limit match applies line b limit action to line b
// R6 - selected external event applies line b external-event action
// R7 - software trigger applies line b soft-trigger action
// R8 - live counter reads in bits 15..0 at 0x10, zero after reset
// R9 - hold a at 0x14 resets zero, writable only in waveform mode
// R10 - hold b at 0x18 resets zero, writable only in waveform mode
// R11 - limit at 0x1c is read/write in both modes, resets zero
// R12 - counter overflow sets wrap flag, bit 0 at 0x20, until next status read
// R13 - capture mode: double load flag when a hold is reloaded unread
// R14 - waveform mode: hold a/b matches set match flags; capture reads zero
// R15 - limit match sets its flag in either mode until the next status read
// R16 - capture mode: hold loads set load flags; waveform reads zero
// R17 - external trigger sets its flag until the next status read
// R18 - status bit 16 shows whether the counter clock is enabled
// R19 - status bit 17 mirrors line a: sensed in capture, driven in waveform
// R20 - status bit 18 mirrors line b: sensed in capture, driven in waveform
// R21 - shaping mode flag 0 selects capture, 1 selects waveform
// R22 - status read clears all sticky flags; a same-cycle event survives
module tcc_top
  import tcc_pkg::*;
#(
  parameter int PRESCALE = TCC_PRESCALE_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic chan_line_a_i,
  output logic chan_line_a_o,
  output logic chan_line_a_oe_o,
  input wire logic chan_line_b_i,
  output logic chan_line_b_o,
  output logic chan_line_b_oe_o,
  input wire logic ext_event_i
);

  function automatic logic apply_action(input logic cur, input logic [1:0] act);
    case (tcc_action_t'(act))
      TCC_ACT_SET: apply_action = 1'b1;
      TCC_ACT_CLEAR: apply_action = 1'b0;
      TCC_ACT_TOGGLE: apply_action = ~cur;
      default: apply_action = cur;
    endcase
  endfunction

  logic [31:0] mode;
  logic [15:0] count_now;
  logic [15:0] hold_a_value;
  logic [15:0] hold_b_value;
  logic [15:0] limit_value;
  logic count_clock_on;
  logic wrap_flag, double_load_flag, match_a_flag, match_b_flag;
  logic match_limit_flag, load_a_flag, load_b_flag, ext_trig_flag;
  logic a_unread, b_unread;
  logic [15:0] div_cnt;
  logic tick;
  logic la_s1, la_s2, la_d, lb_s1, lb_s2, ev_s1, ev_s2, ev_d;

  // bus decode
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_req = req && wb_we_i;
  wire rd_req = req && !wb_we_i;
  wire sel_ctrl = wb_adr_i == TCC_CTRL_OFS;
  wire sel_mode = wb_adr_i == TCC_MODE_OFS;
  wire sel_count = wb_adr_i == TCC_COUNT_OFS;
  wire sel_hold_a = wb_adr_i == TCC_HOLD_A_OFS;
  wire sel_hold_b = wb_adr_i == TCC_HOLD_B_OFS;
  wire sel_limit = wb_adr_i == TCC_LIMIT_OFS;
  wire sel_status = wb_adr_i == TCC_STATUS_OFS;
  wire status_read = rd_req && sel_status; // R22
  wire [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wr_merge_mode = (mode & ~byte_mask) | (wb_dat_i & byte_mask);
  wire [15:0] wr_data16 = wb_dat_i[15:0] & byte_mask[15:0];

  wire wave = mode[TCC_MODE_SHAPING]; // R21
  wire ctrl_wr = wr_req && sel_ctrl && wb_sel_i[0];
  wire clk_en_cmd = ctrl_wr && wb_dat_i[TCC_CTRL_CLK_EN];
  wire clk_dis_cmd = ctrl_wr && wb_dat_i[TCC_CTRL_CLK_DIS];
  wire soft_trig = ctrl_wr && wb_dat_i[TCC_CTRL_SOFT_TRIG];

  // event detection on synchronised levels
  wire ext_evt = ev_s2 && !ev_d;
  wire trig = soft_trig || ext_evt;
  wire step = tick && count_clock_on;
  wire wrap_evt = step && count_now == TCC_COUNT_TOP && !trig; // R12
  wire limit_hit = step && count_now == limit_value; // R15
  wire hit_a = wave && step && count_now == hold_a_value; // R14
  wire hit_b = wave && step && count_now == hold_b_value; // R14
  wire load_a = !wave && la_s2 && !la_d; // capture on rising edge of line a
  wire load_b = !wave && !la_s2 && la_d; // capture on falling edge of line a
  wire overrun = (load_a && a_unread && !(rd_req && sel_hold_a)) ||
                 (load_b && b_unread && !(rd_req && sel_hold_b)); // R13

  // line a: soft trigger beats external event beats limit beats hold a match
  wire a_lim_v = limit_hit ? apply_action(chan_line_a_o, mode[TCC_MODE_A_ON_LIMIT +: 2]) : // R1
                 hit_a ? apply_action(chan_line_a_o, mode[TCC_MODE_A_ON_HOLD_A +: 2]) : chan_line_a_o;
  wire a_ext_v = ext_evt ? apply_action(chan_line_a_o, mode[TCC_MODE_A_ON_EXT +: 2]) : a_lim_v; // R2
  wire next_line_a = soft_trig ? apply_action(chan_line_a_o, mode[TCC_MODE_A_ON_SOFT +: 2]) : a_ext_v; // R3
  wire b_lim_v = limit_hit ? apply_action(chan_line_b_o, mode[TCC_MODE_B_ON_LIMIT +: 2]) : // R5
                 hit_b ? apply_action(chan_line_b_o, mode[TCC_MODE_B_ON_HOLD_B +: 2]) : chan_line_b_o; // R4
  wire b_ext_v = ext_evt ? apply_action(chan_line_b_o, mode[TCC_MODE_B_ON_EXT +: 2]) : b_lim_v; // R6
  wire next_line_b = soft_trig ? apply_action(chan_line_b_o, mode[TCC_MODE_B_ON_SOFT +: 2]) : b_ext_v; // R7

  wire line_a_echo = wave ? chan_line_a_o : la_s2; // R19
  wire line_b_echo = wave ? chan_line_b_o : lb_s2; // R20
  wire [31:0] status_word = {13'h0000, line_b_echo, line_a_echo, count_clock_on, 8'h00,
                             ext_trig_flag, load_b_flag, load_a_flag, match_limit_flag,
                             match_b_flag, match_a_flag, double_load_flag, wrap_flag};
  wire [31:0] next_dat = sel_mode ? mode :
                         sel_count ? {16'h0000, count_now} : // R8
                         sel_hold_a ? {16'h0000, hold_a_value} :
                         sel_hold_b ? {16'h0000, hold_b_value} :
                         sel_limit ? {16'h0000, limit_value} :
                         sel_status ? status_word : 32'h0000_0000;

  // one-cycle answer, unmapped reads give zero, unmapped writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd_req ? next_dat : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= TCC_MODE_RESET;
      limit_value <= TCC_VALUE_RESET; // R11
    end else begin
      if (wr_req && sel_mode)
        mode <= wr_merge_mode;
      if (wr_req && sel_limit)
        limit_value <= (limit_value & ~byte_mask[15:0]) | wr_data16; // R11
    end
  end

  // hold registers: capture loads in capture mode, software writes only in waveform mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_a_value <= TCC_VALUE_RESET; // R9
      hold_b_value <= TCC_VALUE_RESET; // R10
      a_unread <= 1'b0;
      b_unread <= 1'b0;
    end else begin
      if (load_a)
        hold_a_value <= count_now;
      else if (wave && wr_req && sel_hold_a)
        hold_a_value <= (hold_a_value & ~byte_mask[15:0]) | wr_data16; // R9
      if (load_b)
        hold_b_value <= count_now;
      else if (wave && wr_req && sel_hold_b)
        hold_b_value <= (hold_b_value & ~byte_mask[15:0]) | wr_data16; // R10
      a_unread <= load_a || (a_unread && !(rd_req && sel_hold_a));
      b_unread <= load_b || (b_unread && !(rd_req && sel_hold_b));
    end
  end

  // divider giving the counter's enable pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= div_cnt == 16'(PRESCALE - 1);
      div_cnt <= (div_cnt == 16'(PRESCALE - 1)) ? 16'h0000 : div_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_now <= TCC_VALUE_RESET; // R8
      count_clock_on <= 1'b0;
    end else begin
      // a trigger restarts from zero and starts the clock; disable wins over enable and trigger
      count_clock_on <= !clk_dis_cmd && (count_clock_on || clk_en_cmd || trig); // R18
      if (trig)
        count_now <= TCC_VALUE_RESET;
      else if (step)
        count_now <= count_now + 16'h0001;
    end
  end

  // sticky flags: an event in the reading cycle is kept for the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wrap_flag <= 1'b0;
      double_load_flag <= 1'b0;
      match_a_flag <= 1'b0;
      match_b_flag <= 1'b0;
      match_limit_flag <= 1'b0;
      load_a_flag <= 1'b0;
      load_b_flag <= 1'b0;
      ext_trig_flag <= 1'b0;
    end else begin
      wrap_flag <= wrap_evt || (wrap_flag && !status_read); // R12
      double_load_flag <= !wave && (overrun || (double_load_flag && !status_read)); // R13
      match_a_flag <= wave && (hit_a || (match_a_flag && !status_read)); // R14
      match_b_flag <= wave && (hit_b || (match_b_flag && !status_read)); // R14
      match_limit_flag <= limit_hit || (match_limit_flag && !status_read); // R15
      load_a_flag <= !wave && (load_a || (load_a_flag && !status_read)); // R16
      load_b_flag <= !wave && (load_b || (load_b_flag && !status_read)); // R16
      ext_trig_flag <= ext_evt || (ext_trig_flag && !status_read); // R17
    end
  end

  // first stage of each synchroniser feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      la_s1 <= 1'b0;
      la_s2 <= 1'b0;
      la_d <= 1'b0;
      lb_s1 <= 1'b0;
      lb_s2 <= 1'b0;
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
      ev_d <= 1'b0;
    end else begin
      la_s1 <= chan_line_a_i;
      la_s2 <= la_s1;
      la_d <= la_s2;
      lb_s1 <= chan_line_b_i;
      lb_s2 <= lb_s1;
      ev_s1 <= ext_event_i;
      ev_s2 <= ev_s1;
      ev_d <= ev_s2;
    end
  end

  // lines drive only in waveform mode; capture leaves them as inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_line_a_o <= 1'b0;
      chan_line_b_o <= 1'b0;
      chan_line_a_oe_o <= 1'b0;
      chan_line_b_oe_o <= 1'b0;
    end else begin
      chan_line_a_o <= wave ? next_line_a : chan_line_a_o;
      chan_line_b_o <= wave ? next_line_b : chan_line_b_o;
      chan_line_a_oe_o <= wave; // R21
      chan_line_b_oe_o <= wave;
    end
  end

  property p_ack_single;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack held over two cycles");

  property p_count_read;
    @(posedge clk_i) disable iff (rst_i) (rd_req && sel_count) |=> wb_dat_o == {16'h0000, $past(count_now)};
  endproperty
  a_count_read: assert property (p_count_read) else $error("counter read mismatch"); // R8

  property p_hold_a_locked;
    @(posedge clk_i) disable iff (rst_i) (!wave && wr_req && sel_hold_a && !load_a) |=> $stable(hold_a_value);
  endproperty
  a_hold_a_locked: assert property (p_hold_a_locked) else $error("hold a written in capture mode"); // R9

  property p_wrap_set;
    @(posedge clk_i) disable iff (rst_i) wrap_evt |=> wrap_flag ##1 (wrap_flag || $past(status_read));
  endproperty
  a_wrap_set: assert property (p_wrap_set) else $error("wrap flag not kept"); // R12

  property p_match_zero_capture;
    @(posedge clk_i) disable iff (rst_i) !wave |=> !match_a_flag && !match_b_flag;
  endproperty
  a_match_zero_capture: assert property (p_match_zero_capture) else $error("match flag in capture mode"); // R14

  property p_load_zero_wave;
    @(posedge clk_i) disable iff (rst_i) wave |=> !load_a_flag && !load_b_flag && !double_load_flag;
  endproperty
  a_load_zero_wave: assert property (p_load_zero_wave) else $error("load flag in waveform mode"); // R16

  property p_read_clears;
    @(posedge clk_i) disable iff (rst_i) (status_read && !limit_hit && !ext_evt) |=> !match_limit_flag && !ext_trig_flag;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read did not clear"); // R22

  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i) (status_read && limit_hit) |=> match_limit_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on status read"); // R15

  property p_soft_set_a;
    @(posedge clk_i) disable iff (rst_i) (wave && soft_trig && mode[TCC_MODE_A_ON_SOFT +: 2] == 2'b01) |=> chan_line_a_o;
  endproperty
  a_soft_set_a: assert property (p_soft_set_a) else $error("soft trigger did not set line a"); // R3

  property p_soft_toggle_b;
    @(posedge clk_i) disable iff (rst_i)
      (wave && soft_trig && mode[TCC_MODE_B_ON_SOFT +: 2] == 2'b11) |=> chan_line_b_o != $past(chan_line_b_o);
  endproperty
  a_soft_toggle_b: assert property (p_soft_toggle_b) else $error("soft trigger did not toggle line b"); // R7

  property p_clock_status;
    @(posedge clk_i) disable iff (rst_i) clk_dis_cmd |=> !count_clock_on ##0 !status_word[TCC_ST_CLOCK_ON];
  endproperty
  a_clock_status: assert property (p_clock_status) else $error("clock status not cleared"); // R18

  // true when neither trigger overrides a lower-priority line action this cycle
  wire no_trig_act = wave && !ext_evt && !soft_trig;

  property p_limit_a;
    @(posedge clk_i) disable iff (rst_i)
      (no_trig_act && limit_hit && mode[TCC_MODE_A_ON_LIMIT +: 2] == 2'b11)
      |=> chan_line_a_o != $past(chan_line_a_o);
  endproperty
  a_limit_a: assert property (p_limit_a) else $error("limit match did not toggle line a"); // R1

  property p_limit_b;
    @(posedge clk_i) disable iff (rst_i)
      (no_trig_act && limit_hit && mode[TCC_MODE_B_ON_LIMIT +: 2] == 2'b10) |=> !chan_line_b_o;
  endproperty
  a_limit_b: assert property (p_limit_b) else $error("limit match did not clear line b"); // R5

  property p_match_b_line;
    @(posedge clk_i) disable iff (rst_i)
      (no_trig_act && hit_b && !limit_hit && mode[TCC_MODE_B_ON_HOLD_B +: 2] == 2'b11)
      |=> chan_line_b_o != $past(chan_line_b_o);
  endproperty
  a_match_b_line: assert property (p_match_b_line) else $error("hold b match did not toggle line b"); // R4

  property p_ext_a;
    @(posedge clk_i) disable iff (rst_i)
      (wave && ext_evt && !soft_trig && mode[TCC_MODE_A_ON_EXT +: 2] == 2'b11)
      |=> chan_line_a_o != $past(chan_line_a_o);
  endproperty
  a_ext_a: assert property (p_ext_a) else $error("external event did not toggle line a"); // R2

  property p_ext_b;
    @(posedge clk_i) disable iff (rst_i)
      (wave && ext_evt && !soft_trig && mode[TCC_MODE_B_ON_EXT +: 2] == 2'b01) |=> chan_line_b_o;
  endproperty
  a_ext_b: assert property (p_ext_b) else $error("external event did not set line b"); // R6

  property p_hold_b_locked;
    @(posedge clk_i) disable iff (rst_i) (!wave && wr_req && sel_hold_b && !load_b) |=> $stable(hold_b_value);
  endproperty
  a_hold_b_locked: assert property (p_hold_b_locked) else $error("hold b written in capture mode"); // R10

  property p_limit_write;
    @(posedge clk_i) disable iff (rst_i)
      (wr_req && sel_limit && wb_sel_i[1:0] == 2'b11) |=> limit_value == $past(wb_dat_i[15:0]);
  endproperty
  a_limit_write: assert property (p_limit_write) else $error("limit value not written"); // R11

  property p_overrun_set;
    @(posedge clk_i) disable iff (rst_i) (!wave && overrun) |=> double_load_flag;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("double load not flagged"); // R13

  property p_load_a_set;
    @(posedge clk_i) disable iff (rst_i) (!wave && load_a) |=> load_a_flag && hold_a_value == $past(count_now);
  endproperty
  a_load_a_set: assert property (p_load_a_set) else $error("hold a load not flagged"); // R16

  property p_ext_flag;
    @(posedge clk_i) disable iff (rst_i) ext_evt |=> ext_trig_flag;
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("external trigger not flagged"); // R17

  property p_echo_capture;
    @(posedge clk_i) disable iff (rst_i) (rd_req && sel_status && !wave)
      |=> wb_dat_o[TCC_ST_LINE_A_ECHO] == $past(la_s2) && wb_dat_o[TCC_ST_LINE_B_ECHO] == $past(lb_s2);
  endproperty
  a_echo_capture: assert property (p_echo_capture) else $error("line echo differs from sensed level"); // R19 R20

  property p_drive_mode;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> chan_line_a_oe_o == $past(wave) && chan_line_b_oe_o == $past(wave);
  endproperty
  a_drive_mode: assert property (p_drive_mode) else $error("line enable does not follow mode"); // R21

endmodule // tcc_top

// file: test/tcc_line_model.sv
// Purpose: far side of the two channel lines and the external event source
// Assumes: bench calls the tasks; a line driven by the channel shows the driven level
// Notes: no pull resistors on these lines
`timescale 1ns/1ns
module tcc_line_model (
  input wire logic clk_i,
  input wire logic drv_a_i,
  input wire logic oe_a_i,
  input wire logic drv_b_i,
  input wire logic oe_b_i,
  output logic sense_a_o,
  output logic sense_b_o,
  output logic event_o
);
  logic far_a = 1'b0;
  logic far_b = 1'b0;
  initial event_o = 1'b0;
  // the channel wins while it drives; otherwise the far side sets the level
  assign sense_a_o = oe_a_i ? drv_a_i : far_a;
  assign sense_b_o = oe_b_i ? drv_b_i : far_b;
  task automatic drive_a(input logic v);
    @(posedge clk_i);
    far_a <= v;
  endtask
  task automatic drive_b(input logic v);
    @(posedge clk_i);
    far_b <= v;
  endtask
  // long enough for the two-stage input synchroniser to see it
  task automatic pulse_ext();
    @(posedge clk_i);
    event_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    event_o <= 1'b0;
  endtask
endmodule // tcc_line_model

// file: test/testbench.sv
// Purpose: self-checking bench for one timer channel
// Assumes: PRESCALE 2, one idle cycle between bus transfers
// Notes: wrap needs 65536 steps, too long for this run
`timescale 1ns/1ns
module testbench;
  import tcc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, a_o, a_oe, b_o, b_oe, a_i, b_i, ev;
  logic ea = 1'b0;
  logic eb = 1'b0;
  int fail_count = 0;
  int compares = 0;
  always #50 clk_i = ~clk_i;
  tcc_top #(.PRESCALE(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .chan_line_a_i(a_i), .chan_line_a_o(a_o), .chan_line_a_oe_o(a_oe),
    .chan_line_b_i(b_i), .chan_line_b_o(b_o), .chan_line_b_oe_o(b_oe), .ext_event_i(ev));
  tcc_line_model lm (.clk_i(clk_i), .drv_a_i(a_o), .oe_a_i(a_oe), .drv_b_i(b_o), .oe_b_i(b_oe),
    .sense_a_o(a_i), .sense_b_o(b_i), .event_o(ev));
  task automatic final_report();
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40) begin
      fail_count++;
      final_report();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    wb(1'b0, a, 32'h0000_0000);
    check(q & m, exp);
  endtask
  function automatic logic act(input logic cur, input logic [1:0] c);
    case (c)
      2'b00: return cur;
      2'b01: return 1'b1;
      2'b10: return 1'b0;
      default: return ~cur;
    endcase
  endfunction
  function automatic logic [31:0] echo(input logic a, input logic b, input logic clk_on);
    return {13'h0000, b, a, clk_on, 16'h0000};
  endfunction
  task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
      rd(8'(8'h10 + 4 * i), 32'h0000_0000, 32'hffff_ffff);
    end
  endtask
  task automatic t_regs();
    wb(1'b1, TCC_HOLD_A_OFS, 32'h0000_1111);
    rd(TCC_HOLD_A_OFS, 32'h0000_0000, 32'h0000_ffff);
    wb(1'b1, TCC_HOLD_B_OFS, 32'h0000_2222);
    rd(TCC_HOLD_B_OFS, 32'h0000_0000, 32'h0000_ffff);
    wb(1'b1, TCC_LIMIT_OFS, 32'h0000_3333);
    rd(TCC_LIMIT_OFS, 32'h0000_3333, 32'h0000_ffff);
    wb(1'b1, TCC_MODE_OFS, 32'h0000_8000);
    wb(1'b1, TCC_HOLD_A_OFS, 32'h0000_a5a5);
    rd(TCC_HOLD_A_OFS, 32'h0000_a5a5, 32'h0000_ffff);
    wb(1'b1, TCC_HOLD_B_OFS, 32'h0000_5a5a);
    rd(TCC_HOLD_B_OFS, 32'h0000_5a5a, 32'h0000_ffff);
    wb(1'b1, TCC_LIMIT_OFS, 32'h0000_0000);
    rd(TCC_LIMIT_OFS, 32'h0000_0000, 32'h0000_ffff);
    rd(8'h3c, 32'h0000_0000, 32'hffff_ffff);
    rd(TCC_COUNT_OFS, 32'h0000_0000, 32'hffff_ffff);
  endtask
  task automatic t_soft();
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, TCC_MODE_OFS, 32'h0000_8000 | 32'(c << TCC_MODE_A_ON_SOFT) | 32'((3 - c) << TCC_MODE_B_ON_SOFT));
      ea = act(ea, 2'(c));
      eb = act(eb, 2'(3 - c));
      wb(1'b1, TCC_CTRL_OFS, 32'h0000_0004);
      @(posedge clk_i);
      check({a_o, b_o}, {ea, eb});
      rd(TCC_STATUS_OFS, echo(ea, eb, 1'b1), 32'h0007_0000);
    end
    wb(1'b1, TCC_CTRL_OFS, 32'h0000_0002);
    rd(TCC_STATUS_OFS, 32'h0000_0000, 32'h0001_0000);
    wb(1'b1, TCC_CTRL_OFS, 32'h0000_0001);
    rd(TCC_STATUS_OFS, 32'h0001_0000, 32'h0001_0000);
    wb(1'b1, TCC_CTRL_OFS, 32'h0000_0003);
    rd(TCC_STATUS_OFS, 32'h0000_0000, 32'h0001_0000);
  endtask
  task automatic t_ext();
    wb(1'b1, TCC_MODE_OFS, 32'h1030_8000);
    ea = ~ea;
    eb = 1'b1;
    lm.pulse_ext();
    repeat (8) @(posedge clk_i);
    check({a_o, b_o}, {ea, eb});
    rd(TCC_STATUS_OFS, echo(ea, eb, 1'b1) | 32'h0000_0080, 32'h0007_0080);
    rd(TCC_STATUS_OFS, echo(ea, eb, 1'b1), 32'h0007_0080);
  endtask
  task automatic t_match();
    wb(1'b1, TCC_CTRL_OFS, 32'h0000_0002);
    wb(1'b1, TCC_HOLD_A_OFS, 32'h0000_0002);
    wb(1'b1, TCC_HOLD_B_OFS, 32'h0000_0002);
    wb(1'b1, TCC_LIMIT_OFS, 32'h0000_0006);
    // a sets on hold a then toggles on limit; b toggles on hold b then clears on limit
    wb(1'b1, TCC_MODE_OFS, 32'h0b0d_8000);
    rd(TCC_STATUS_OFS, echo(ea, eb, 1'b0), 32'h0007_00ff);
    wb(1'b1, TCC_CTRL_OFS, 32'h0000_0004);
    repeat (9) @(posedge clk_i);
    check({a_o, b_o}, {1'b1, ~eb});
    repeat (12) @(posedge clk_i);
    ea = 1'b0;
    eb = 1'b0;
    check({a_o, b_o}, {ea, eb});
    rd(TCC_STATUS_OFS, echo(ea, eb, 1'b1) | 32'h0000_001c, 32'h0007_00ff);
    rd(TCC_STATUS_OFS, echo(ea, eb, 1'b1), 32'h0007_00ff);
  endtask
  task automatic t_capture();
    wb(1'b1, TCC_CTRL_OFS, 32'h0000_0002);
    wb(1'b1, TCC_MODE_OFS, 32'h0000_0000);
    @(posedge clk_i);
    check({a_oe, b_oe}, 2'b00);
    wb(1'b1, TCC_CTRL_OFS, 32'h0000_0004);
    lm.drive_b(1'b1);
    for (int i = 0; i < 3; i++) begin
      lm.drive_a(i[0] == 1'b0);
      repeat (8) @(posedge clk_i);
    end
    rd(TCC_STATUS_OFS, 32'h0006_0062, 32'h0006_006e);
    rd(TCC_STATUS_OFS, 32'h0006_0000, 32'h0006_0062);
  endtask
  // reset again from a busy state so the reset values are really tested
  task automatic t_midreset();
    lm.drive_a(1'b0);
    lm.drive_b(1'b0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check({a_o, b_o, a_oe, b_oe}, 32'h0000_0000);
    t_reset();
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_soft();
    t_ext();
    t_match();
    t_capture();
    t_midreset();
    final_report();
  end
endmodule // testbench
